// ===== tb_wdr_top.sv
// Self-checking testbench for the watchdog restart block
`timescale 1ns/10ps
`include "wdr_regs.vh"
module tb_wdr_top;
  localparam [3:0]  PS    = 4'h2;
  localparam [11:0] A_KEY = {`WDR_IDX_KEY, 2'b00};
  localparam [11:0] A_CTL = {`WDR_IDX_CTRL, 2'b00};
  localparam [11:0] A_ST  = {`WDR_IDX_STAT, 2'b00};
  localparam [11:0] A_MSK = {`WDR_IDX_MASK, 2'b00};
  localparam [11:0] A_CNT = {`WDR_IDX_CNT, 2'b00};
  reg         pclk, presetn, psel, penable, pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, seed, rd, n0;
  reg  [7:0]  b;
  reg         err;
  wire [31:0] prdata;
  wire        pready, pslverr, wdog_reset, irq;
  integer     mismatches, n_tests, nres, cyc, i;
  wdr_top #(.PER_SHIFT(PS)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wdog_reset(wdog_reset), .irq(irq));
  // ----------------------------------------
  // Clock, reset pulse counter, timeout
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (presetn && wdog_reset === 1'b1) nres = nres + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      test_done;
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function integer per(input [2:0] r);
    per = 1 << (PS + r);
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
    end
  endtask
  task rdc(input [11:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0;
    seed = 32'hD81C3BEA; mismatches = 0; n_tests = 0; nres = 0; cyc = 0;
    idle(16);
    presetn <= 1'b1;
    rdc(A_CTL, 0); rdc(A_ST, 0); rdc(A_MSK, 0); rdc(A_CNT, 0);
    rdc(A_KEY, 0);
    apb(1'b0, 12'h100, 0);
    chk(err, 1);
    apb(1'b1, A_KEY, 32'h12); idle(2);
    chk(nres, 0);
    rdc(A_ST, 0);
    apb(1'b1, A_MSK, 32'hF); apb(1'b1, A_CTL, 32'h3);
    for (i = 0; i < 5; i = i + 1) begin
      seed = xs(seed);
      b = (i == 0) ? 8'h54 : seed[7:0];
      if (b == `WDR_KEY_ARM || b == `WDR_KEY_FIRE) b = 8'hFF;
      n0 = nres;
      apb(1'b1, A_KEY, {seed[31:8], b}); idle(2);
      chk(nres, n0 + 1);
    end
    rdc(A_ST, 32'h2);
    chk(irq, 1);
    apb(1'b1, A_ST, 32'h2); idle(2);
    chk(irq, 0);
    apb(1'b1, A_CTL, 32'h3); n0 = nres;
    apb(1'b1, A_KEY, 32'hAA); idle(2);
    chk(nres, n0);
    rdc(A_ST, 0);
    for (i = 0; i < 12; i = i + 1) begin
      seed = xs(seed);
      apb(1'b1, A_KEY, 32'h55);
      if (seed[8]) apb(1'b1, A_KEY, 32'h55);
      idle(seed[2:0] % 6);
      apb(1'b1, A_KEY, 32'hAA);
      idle(seed[6:4]);
    end
    chk(nres, n0);
    rdc(A_ST, 1);
    apb(1'b1, A_ST, 32'hF); n0 = nres; idle(per(3) + 2);
    chk(nres, n0 + 1);
    rdc(A_ST, 4);
    apb(1'b1, A_ST, 32'hF); apb(1'b1, A_CTL, 32'hB); n0 = nres;
    apb(1'b1, A_KEY, 32'h55); idle(2);
    chk(nres, n0 + 1);
    rdc(A_ST, 8);
    apb(1'b1, A_CTL, 32'hB); idle(per(3) * 3 / 4 - 1);
    apb(1'b1, A_KEY, 32'h55); apb(1'b1, A_KEY, 32'hAA); idle(2);
    chk(nres, n0 + 1);
    rdc(A_ST, 9);
    apb(1'b1, A_ST, 32'hF); apb(1'b1, A_MSK, 32'h0);
    apb(1'b1, A_KEY, 32'h12); idle(2);
    chk(irq, 0);
    presetn <= 1'b0; idle(2); presetn <= 1'b1;
    rdc(A_CTL, 0);
    rdc(A_CNT, 0);
    test_done;
  end
endmodule

// ===== wdr_period_cnt.v
// Time-out period counter with end-of-period and window-open detection
`timescale 1ns/10ps
`include "wdr_regs.vh"
module wdr_period_cnt #(
  parameter [3:0] PER_SHIFT = `WDR_PER_SHIFT
) (
  input  wire                  pclk,
  input  wire                  presetn,
  input  wire                  run,
  input  wire                  restart,
  input  wire [2:0]            rate,
  output wire [`WDR_CNT_W-1:0] count,
  output wire                  expire,
  output wire                  early
);

  reg  [`WDR_CNT_W-1:0] count_q;
  reg  [`WDR_CNT_W-1:0] count_d;
  wire [3:0]            shamt;
  wire [`WDR_CNT_W-1:0] period;
  wire [`WDR_CNT_W-1:0] last;
  wire [`WDR_CNT_W-1:0] open_at;
  wire                  at_last;

  // ---------------------------------------------------------------
  // Period length: two to the power of base shift plus rate
  // ---------------------------------------------------------------
  assign shamt   = PER_SHIFT + {1'b0, rate};
  assign period  = {{(`WDR_CNT_W-1){1'b0}}, 1'b1} << shamt;
  assign last    = period - {{(`WDR_CNT_W-1){1'b0}}, 1'b1};
  assign open_at = period - (period >> 2); // Last quarter opens here
  assign at_last = (count_q == last);

  // Next count: cleared on restart, disable or wrap
  always @* begin
    count_d = count_q + {{(`WDR_CNT_W-1){1'b0}}, 1'b1};
    if (!run || restart || at_last) begin
      count_d = {`WDR_CNT_W{1'b0}};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= {`WDR_CNT_W{1'b0}};
    end else begin
      count_q <= count_d;
    end
  end

  assign count  = count_q;
  assign expire = run & at_last & ~restart;
  assign early  = count_q < open_at;

endmodule

// ===== wdr_regs.vh
// Register map, field positions and reset values of the watchdog restart block
`ifndef WDR_REGS_VH
`define WDR_REGS_VH

// ---------------------------------------------------------------
// Register indices (byte address = index * 4)
// ---------------------------------------------------------------
`define WDR_IDX_KEY      10'h00F
`define WDR_IDX_CTRL     10'h010
`define WDR_IDX_STAT     10'h011
`define WDR_IDX_MASK     10'h012
`define WDR_IDX_CNT      10'h013

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define WDR_CTRL_RATE_LSB 0
`define WDR_CTRL_RATE_MSB 2
`define WDR_CTRL_WIN_BIT  3
`define WDR_CTRL_RESET    4'h0
`define WDR_RATE_OFF      3'h0

// ---------------------------------------------------------------
// Status and mask fields
// ---------------------------------------------------------------
`define WDR_EV_RESTART    0
`define WDR_EV_BADKEY     1
`define WDR_EV_EXPIRE     2
`define WDR_EV_EARLY      3
`define WDR_EV_W          4
`define WDR_MASK_RESET    4'h0

// ---------------------------------------------------------------
// Key values and timing
// ---------------------------------------------------------------
`define WDR_KEY_ARM       8'h55
`define WDR_KEY_FIRE      8'hAA
`define WDR_PER_SHIFT     4'h6
`define WDR_CNT_W         16

`endif

// ===== wdr_sticky.v
// Sticky event flags, set by hardware, cleared by writing one
`timescale 1ns/10ps
module wdr_sticky #(
  parameter W = 4
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] set_evt,
  input  wire [W-1:0] clr_w1c,
  output wire [W-1:0] flags
);

  reg [W-1:0] flags_q;
  wire [W-1:0] flags_d;

  // ---------------------------------------------------------------
  // Flag update: a set in the clearing cycle survives
  // ---------------------------------------------------------------
  assign flags_d = (flags_q & ~clr_w1c) | set_evt;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= {W{1'b0}};
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

endmodule

// ===== wdr_top.v
// Watchdog restart key sequencer with APB registers and interrupt
//
// Functional notes
// - Rate select zero disables watchdog; key writes then do nothing.
// - Any nonzero rate select enables the watchdog and key checking.
// - Enabled, a key write other than 0x55 or 0xAA resets at once.
// - Among key writes, only 0xAA after 0x55 restarts the period; repeated 0x55 allowed.
// - Writes may be apart but must finish before period end, else reset.
// - Window mode: any key write in first three quarters resets.
// - Key register reads zero; writes accepted any time.
`timescale 1ns/10ps
`include "wdr_regs.vh"
module wdr_top #(
  parameter [3:0] PER_SHIFT = `WDR_PER_SHIFT
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        wdog_reset,
  output wire        irq
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  reg  [3:0]            ctrl_q;
  reg  [3:0]            ctrl_d;
  reg  [`WDR_EV_W-1:0]  mask_q;
  reg  [`WDR_EV_W-1:0]  mask_d;
  reg                   armed_q;
  reg                   armed_d;
  reg                   wdrst_q;
  reg                   wdrst_d;
  reg                   irq_q;
  reg  [31:0]           prdata_q;
  reg  [31:0]           prdata_d;
  reg                   pslverr_q;
  reg                   pslverr_d;
  reg  [`WDR_EV_W-1:0]  ev_set;
  reg                   restart;
  reg                   bad_key;
  reg                   early_wr;

  wire [9:0]            idx;
  wire                  setup_ph;
  wire                  access_ph;
  wire                  wr_acc;
  wire                  hit_key;
  wire                  hit_ctrl;
  wire                  hit_stat;
  wire                  hit_mask;
  wire                  hit_cnt;
  wire                  mapped;
  wire [7:0]            key_byte;
  wire [2:0]            rate;
  wire                  win_mode;
  wire                  wd_on;
  wire                  key_wr;
  wire [`WDR_EV_W-1:0]  stat_w1c;
  wire [`WDR_EV_W-1:0]  stat_flags;
  wire [`WDR_CNT_W-1:0] count;
  wire                  expire;
  wire                  early;
  // Counter control
  wire                  trip;
  wire                  cnt_run;
  wire                  cnt_restart;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  // Word map: key 0x0F, control 0x10, status 0x11, mask 0x12, count 0x13
  // Control holds rate select in bits 2:0 and window mode in bit 3
  // Status and mask: restart, bad key, expiry, early window write
  // Byte address bits 1:0 are ignored; every register is one word
  assign idx       = paddr[11:2];
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_acc    = access_ph & pwrite;

  // Register hits by word index
  assign hit_key  = (idx == `WDR_IDX_KEY);
  assign hit_ctrl = (idx == `WDR_IDX_CTRL);
  assign hit_stat = (idx == `WDR_IDX_STAT);
  assign hit_mask = (idx == `WDR_IDX_MASK);
  assign hit_cnt  = (idx == `WDR_IDX_CNT);
  assign mapped   = hit_key | hit_ctrl | hit_stat | hit_mask | hit_cnt;

  assign key_byte = pwdata[7:0];
  assign key_wr   = wr_acc & hit_key;
  assign stat_w1c = (wr_acc & hit_stat) ? pwdata[`WDR_EV_W-1:0]
                                        : {`WDR_EV_W{1'b0}};

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  assign rate     = ctrl_q[`WDR_CTRL_RATE_MSB:`WDR_CTRL_RATE_LSB];
  assign win_mode = ctrl_q[`WDR_CTRL_WIN_BIT];
  // Rate select zero parks the counter and disables every key check
  // enable from rate
  assign wd_on    = (rate != `WDR_RATE_OFF);

  // Control and mask register writes
  always @* begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    if (wr_acc && hit_ctrl) begin
      ctrl_d = pwdata[3:0];
    end
    if (wr_acc && hit_mask) begin
      mask_d = pwdata[`WDR_EV_W-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `WDR_CTRL_RESET;
      mask_q <= `WDR_MASK_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
    end
  end

  // ---------------------------------------------------------------
  // Key sequence checking
  // ---------------------------------------------------------------
  // Classify each key write against state and window
  // The arm flag remembers a 0x55 until 0xAA, a trip or expiry
  always @* begin
    armed_d  = armed_q;
    restart  = 1'b0;
    bad_key  = 1'b0;
    early_wr = 1'b0;
    if (!wd_on) begin
      armed_d = 1'b0;
    end else if (key_wr) begin
      // Window check comes first, so even a key value is refused early
      // early write in window mode
      if (win_mode && early) begin
        early_wr = 1'b1;
        armed_d  = 1'b0;
      end else if (key_byte == `WDR_KEY_ARM) begin
        armed_d = 1'b1;
      end else if (key_byte == `WDR_KEY_FIRE) begin
        restart = armed_q;
        // A lone 0xAA is dropped without a reset
        armed_d = 1'b0;
      end else begin
        bad_key = 1'b1;
        armed_d = 1'b0;
      end
    end
    if (expire) begin
      armed_d = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= armed_d;
    end
  end

  // ---------------------------------------------------------------
  // Period counter
  // ---------------------------------------------------------------
  // Immediate trips zero the count at once; expiry is left out,
  // since it derives from the count and would close a loop
  assign trip        = bad_key | early_wr;
  assign cnt_run     = wd_on & ~trip;

  // reload on completed sequence
  // Completed key sequence or any control write opens a new period
  assign cnt_restart = restart | (wr_acc & hit_ctrl);

  wdr_period_cnt #(
    .PER_SHIFT (PER_SHIFT)
  ) u_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (cnt_run),
    .restart (cnt_restart),
    .rate    (rate),
    .count   (count),
    .expire  (expire),
    .early   (early)
  );

  // ---------------------------------------------------------------
  // Watchdog reset output
  // ---------------------------------------------------------------
  // expiry or bad write resets
  // Registered so the reset controller sees a clean one-cycle pulse
  always @* begin
    wdrst_d = wd_on & (trip | expire);
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdrst_q <= 1'b0;
    end else begin
      wdrst_q <= wdrst_d;
    end
  end

  assign wdog_reset = wdrst_q;

  // ---------------------------------------------------------------
  // Event status and interrupt
  // ---------------------------------------------------------------
  // Event vector for sticky flags
  always @* begin
    ev_set = {`WDR_EV_W{1'b0}};
    ev_set[`WDR_EV_RESTART] = restart;
    ev_set[`WDR_EV_BADKEY]  = bad_key;
    ev_set[`WDR_EV_EXPIRE]  = expire;
    ev_set[`WDR_EV_EARLY]   = early_wr;
  end

  wdr_sticky #(
    .W (`WDR_EV_W)
  ) u_stat (
    .pclk    (pclk),
    .presetn (presetn),
    .set_evt (ev_set),
    .clr_w1c (stat_w1c),
    .flags   (stat_flags)
  );

  // Level interrupt from unmasked flags
  // Registered, so it trails a new flag by one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_flags & mask_q);
    end
  end

  assign irq = irq_q;

  // ---------------------------------------------------------------
  // Read data and error, captured in the setup cycle
  // ---------------------------------------------------------------
  // Capturing at setup keeps prdata steady through the access cycle,
  // and an unmapped index answers with zero data and an error
  always @* begin
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (setup_ph) begin
      prdata_d  = 32'h0000_0000;
      pslverr_d = ~mapped;
      if (!pwrite) begin
        if (hit_ctrl) begin
          prdata_d[3:0] = ctrl_q;
        end
        if (hit_stat) begin
          prdata_d[`WDR_EV_W-1:0] = stat_flags;
        end
        if (hit_mask) begin
          prdata_d[`WDR_EV_W-1:0] = mask_q;
        end
        if (hit_cnt) begin
          prdata_d[`WDR_CNT_W-1:0] = count;
        end
        if (hit_key) begin
          prdata_d = 32'h0000_0000;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Zero wait states
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q & access_ph;

endmodule

// ===== wdr_top_monitor.sv
// Assertion checker for the watchdog restart block
`timescale 1ns/10ps
`include "wdr_regs.vh"
module wdr_monitor (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        wdog_reset,
  input wire        irq
);
  // ----------------------------------------
  // Bus decode and shadow of control fields
  // ----------------------------------------
  wire       acc = psel & penable;
  wire [9:0] idx = paddr[11:2];
  wire       kw  = acc & pwrite & (idx == `WDR_IDX_KEY);
  wire       map = (idx >= `WDR_IDX_KEY) && (idx <= `WDR_IDX_CNT);
  wire       bad = (pwdata[7:0] != `WDR_KEY_ARM) && (pwdata[7:0] != `WDR_KEY_FIRE);
  reg  [2:0] rate_q;
  reg  [3:0] mask_q;
  // Track rate and mask writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_q <= 3'h0;
      mask_q <= 4'h0;
    end else if (acc & pwrite & (idx == `WDR_IDX_CTRL)) begin
      rate_q <= pwdata[2:0];
    end else if (acc & pwrite & (idx == `WDR_IDX_MASK)) begin
      mask_q <= pwdata[3:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_off; kw && rate_q == 3'h0 |=> !wdog_reset; endproperty
  a_off: assert property (p_off)
    else $error("reset after key write while disabled");
  property p_bad; kw && rate_q != 3'h0 && bad |=> wdog_reset; endproperty
  a_bad: assert property (p_bad)
    else $error("no reset after wrong key");
  property p_rd0; psel && !penable && !pwrite && idx == `WDR_IDX_KEY |=> prdata == 32'h0;
  endproperty
  a_rd0: assert property (p_rd0)
    else $error("key register read not zero");
  property p_pulse; $rose(wdog_reset) |=> !wdog_reset [*2]; endproperty
  a_pulse: assert property (p_pulse)
    else $error("reset pulse longer than one cycle");
  property p_err; acc && !map |-> pslverr; endproperty
  a_err: assert property (p_err)
    else $error("unmapped access without error");
  property p_ok; acc && map |-> !pslverr; endproperty
  a_ok: assert property (p_ok)
    else $error("mapped access flagged as error");
  property p_irq; mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !irq; endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt with all events masked");
  property p_rdy; psel |-> pready; endproperty
  a_rdy: assert property (p_rdy)
    else $error("ready low during transfer");
endmodule
bind wdr_top wdr_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .wdog_reset(wdog_reset), .irq(irq));
